// File: core/mra_pkg.sv
// constants, types and field layout for the meter register access block
package mra_pkg;
  // ==========================================================
  // serial command layout
  localparam int CMD_BITS = 8; // command byte length
  localparam int ADDR_W = 5; // register select width
  localparam int DATA_W = 16; // widest register served
  localparam int CMD_DIR_BIT = 7; // 1 = write, 0 = read
  // ==========================================================
  // register map
  localparam logic [4:0] MODE_ADDR = 5'h06; // configuration register
  localparam logic [15:0] MODE_RESET = 16'h000C; // power-on value
  localparam logic [4:0] MODE_BITS = 5'h10; // configuration width
  localparam logic [4:0] OTHER_BITS = 5'h08; // width of unserved addresses
  // ==========================================================
  // configuration field positions
  localparam int HPF_OFF_POS = 0;
  localparam int LPF_OFF_POS = 1;
  localparam int PULSE_OFF_POS = 2;
  localparam int DIP_OFF_POS = 3;
  localparam int SUSPEND_POS = 4;
  localparam int TEMP_START_POS = 5;
  localparam int SOFT_RST_POS = 6;
  localparam int CYC_MODE_POS = 7;
  localparam int CH1_SHORT_POS = 8;
  localparam int CH2_SHORT_POS = 9;
  localparam int EXCHANGE_POS = 10;
  localparam int RATE_LSB = 11;
  localparam int SRC_LSB = 13;
  localparam int TEST_POS = 15;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 100; // master clock period
  localparam int SOFT_CHIP_RESET_WAIT_NS = 18000; // quiet time after soft reset
  localparam int SOFT_CHIP_RESET_CYC = (SOFT_CHIP_RESET_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RATE_CNT_W = 10; // divider up to 1024
  // ==========================================================
  // fsm states, one-hot
  typedef enum logic [3:0] {
    ST_CMD = 4'b0001, // collecting command byte
    ST_WR = 4'b0010, // collecting write data
    ST_RD = 4'b0100, // shifting read data out
    ST_RST = 4'b1000 // soft reset quiet time
  } mra_state_e;
  // configuration register, msb first
  typedef struct packed {
    logic factory_test_mode; // 15
    logic [1:0] waveform_source_sel; // 14:13
    logic [1:0] waveform_rate_sel; // 12:11
    logic channel_input_exchange; // 10
    logic ch2_input_short; // 9
    logic ch1_input_short; // 8
    logic line_cycle_accum_mode; // 7
    logic soft_chip_reset; // 6
    logic temp_conversion_start; // 5
    logic converter_suspend; // 4
    logic dip_detect_off; // 3
    logic pulse_output_off; // 2
    logic product_lowpass_off; // 1
    logic highpass_off; // 0
  } mra_mode_s;
  // serial pins toward the host
  typedef struct packed {
    logic sclk; // serial clock
    logic din; // data from host
    logic cs_n; // frame select, low active
  } mra_serial_in_s;
endpackage

// File: core/mra_top.sv
// serial register front end and configuration register of the meter
`timescale 1ns/1ps
module mra_top (
  input wire logic sys_clk_in, // master clock, 10 MHz
  input wire logic rstn_in, // async reset, low active
  input mra_pkg::mra_serial_in_s serial_in, // host serial pins
  input wire logic temp_done_in, // temperature conversion finished
  output logic dout_out, // serial data to host
  output logic dout_oe_out, // high while driving dout
  output mra_pkg::mra_mode_s mode_out, // configuration fields
  output logic soft_reset_out, // chip reset during quiet time
  output logic wave_update_out // waveform update strobe
);
  import mra_pkg::*;

  // ==========================================================
  // reset release
  logic rst_meta_reg; // first stage, read by second only
  logic rstn_sync_reg; // released reset copy

  // two-stage release of the async reset
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rst_meta_reg <= 1'b0;
      rstn_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rstn_sync_reg <= rst_meta_reg;
    end
  end

  // ==========================================================
  // helpers
  // bits carried by a register at an address
  function automatic logic [4:0] reg_bits(input logic [4:0] addr);
    reg_bits = (addr == MODE_ADDR) ? MODE_BITS : OTHER_BITS;
  endfunction

  // mask of low counter bits for a waveform rate code
  function automatic logic [RATE_CNT_W-1:0] rate_mask(input logic [1:0] sel);
    case (sel)
      2'h0: rate_mask = 10'h07F; // divide by 128
      2'h1: rate_mask = 10'h0FF; // divide by 256
      2'h2: rate_mask = 10'h1FF; // divide by 512
      default: rate_mask = 10'h3FF; // divide by 1024
    endcase
  endfunction

  // ==========================================================
  // state and datapath declarations
  mra_state_e state_reg; // transfer state
  logic sclk_prev_reg; // serial clock last cycle
  logic [DATA_W-1:0] in_sh_reg; // incoming shift
  logic [DATA_W-1:0] out_sh_reg; // outgoing shift
  logic [4:0] bit_cnt_reg; // bits done in this phase
  logic [4:0] addr_reg; // selected register
  logic [4:0] len_reg; // bits to move for this register
  logic [7:0] rst_cnt_reg; // quiet time counter
  mra_mode_s mode_reg; // configuration register
  logic [RATE_CNT_W-1:0] rate_cnt_reg; // waveform divider
  logic wave_reg; // waveform strobe

  logic rise; // serial clock rising
  logic fall; // serial clock falling
  logic [DATA_W-1:0] shift_next; // in shift after this bit
  logic cmd_done; // command byte complete
  logic wr_done; // write data complete
  logic rd_done; // read data complete
  logic [4:0] cmd_len; // width for the new address

  assign rise = serial_in.sclk & ~sclk_prev_reg;
  assign fall = ~serial_in.sclk & sclk_prev_reg;
  assign shift_next = {in_sh_reg[DATA_W-2:0], serial_in.din};
  assign cmd_done = (state_reg == ST_CMD) && !serial_in.cs_n && rise
                    && (bit_cnt_reg == 5'(CMD_BITS - 1));
  assign wr_done = (state_reg == ST_WR) && !serial_in.cs_n && rise
                   && (bit_cnt_reg == len_reg - 5'h01);
  assign rd_done = (state_reg == ST_RD) && !serial_in.cs_n && rise
                   && (bit_cnt_reg == len_reg - 5'h01);
  assign cmd_len = reg_bits(shift_next[ADDR_W-1:0]);

  // ==========================================================
  // serial clock history
  always_ff @(posedge sys_clk_in or negedge rstn_sync_reg)
  begin
    if (!rstn_sync_reg)
      sclk_prev_reg <= 1'b1; // idle level of a parked clock, no false rise
    else
      sclk_prev_reg <= serial_in.sclk;
  end

  // ==========================================================
  // transfer state machine
  always_ff @(posedge sys_clk_in or negedge rstn_sync_reg)
  begin
    if (!rstn_sync_reg)
    begin
      state_reg <= ST_CMD;
      bit_cnt_reg <= 5'h00;
      addr_reg <= 5'h00;
      len_reg <= OTHER_BITS;
      rst_cnt_reg <= 8'h00;
    end
    else
    begin
      case (state_reg)
        ST_CMD:
        begin
          if (serial_in.cs_n)
            bit_cnt_reg <= 5'h00; // frame ended, restart byte
          else if (cmd_done)
          begin
            // bits 6:5 ignored; top bit picks direction
            addr_reg <= shift_next[ADDR_W-1:0];
            len_reg <= cmd_len;
            bit_cnt_reg <= 5'h00;
            if (shift_next[CMD_DIR_BIT])
              state_reg <= ST_WR;
            else
              state_reg <= ST_RD;
          end
          else if (rise)
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
        ST_WR, ST_RD:
        begin
          if (serial_in.cs_n)
          begin
            state_reg <= ST_CMD; // aborted frame
            bit_cnt_reg <= 5'h00;
          end
          else if (wr_done && addr_reg == MODE_ADDR && shift_next[SOFT_RST_POS])
          begin
            state_reg <= ST_RST;
            rst_cnt_reg <= 8'(SOFT_CHIP_RESET_CYC - 1);
          end
          else if (wr_done || rd_done)
          begin
            state_reg <= ST_CMD;
            bit_cnt_reg <= 5'h00;
          end
          else if (rise)
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
        ST_RST:
        begin
          // serial pins ignored until quiet time ends
          if (rst_cnt_reg == 8'h00)
          begin
            state_reg <= ST_CMD;
            bit_cnt_reg <= 5'h00;
          end
          else
            rst_cnt_reg <= rst_cnt_reg - 8'h01;
        end
        default:
          state_reg <= ST_CMD;
      endcase
    end
  end

  // ==========================================================
  // incoming shift register, msb first
  always_ff @(posedge sys_clk_in or negedge rstn_sync_reg)
  begin
    if (!rstn_sync_reg)
      in_sh_reg <= '0;
    else if (rise && !serial_in.cs_n)
      in_sh_reg <= shift_next;
  end

  // ==========================================================
  // read path: load at decode, change on falling edges
  always_ff @(posedge sys_clk_in or negedge rstn_sync_reg)
  begin
    if (!rstn_sync_reg)
    begin
      out_sh_reg <= '0;
      dout_out <= 1'b0;
      dout_oe_out <= 1'b0;
    end
    else if (cmd_done && !shift_next[CMD_DIR_BIT])
    begin
      // left align the register, unserved addresses read zero
      if (shift_next[ADDR_W-1:0] == MODE_ADDR)
        out_sh_reg <= mode_reg << 1;
      else
        out_sh_reg <= '0;
      dout_out <= (shift_next[ADDR_W-1:0] == MODE_ADDR) ? mode_reg[DATA_W-1] : 1'b0;
      dout_oe_out <= 1'b1;
    end
    else if (rd_done || serial_in.cs_n || state_reg != ST_RD)
    begin
      dout_oe_out <= 1'b0;
      dout_out <= 1'b0;
    end
    else if (fall && bit_cnt_reg != 5'h00)
    begin
      dout_out <= out_sh_reg[DATA_W-1];
      out_sh_reg <= out_sh_reg << 1;
    end
  end

  // ==========================================================
  // configuration register
  always_ff @(posedge sys_clk_in or negedge rstn_sync_reg)
  begin
    if (!rstn_sync_reg)
      mode_reg <= MODE_RESET;
    else if (state_reg == ST_RST)
      mode_reg <= MODE_RESET; // soft reset restores defaults
    else if (wr_done && addr_reg == MODE_ADDR)
      mode_reg <= shift_next; // host write beats done
    else if (temp_done_in)
      mode_reg.temp_conversion_start <= 1'b0;
  end

  // fields drive the datapath straight from the register
  assign mode_out = mode_reg;

  // soft reset strobe, held for the quiet time
  always_ff @(posedge sys_clk_in or negedge rstn_sync_reg)
  begin
    if (!rstn_sync_reg)
      soft_reset_out <= 1'b0;
    else
      soft_reset_out <= (state_reg == ST_RST) && (rst_cnt_reg != 8'h00);
  end

  // ==========================================================
  // waveform update divider
  always_ff @(posedge sys_clk_in or negedge rstn_sync_reg)
  begin
    if (!rstn_sync_reg)
    begin
      rate_cnt_reg <= '0;
      wave_reg <= 1'b0;
    end
    else
    begin
      rate_cnt_reg <= rate_cnt_reg + 10'h001;
      wave_reg <= (rate_cnt_reg & rate_mask(mode_reg.waveform_rate_sel))
                  == rate_mask(mode_reg.waveform_rate_sel);
    end
  end
  assign wave_update_out = wave_reg;

  // ==========================================================
  // checks
  sequence cmd_byte_s;
    cmd_done;
  endsequence

  sequence rst_quiet_s;
    (state_reg == ST_RST)[*8];
  endsequence

  cmd_decode_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_sync_reg)
    cmd_byte_s |=> state_reg != ST_CMD)
    else $error("command byte not decoded");

  addr_take_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_sync_reg)
    cmd_byte_s |=> addr_reg == $past(shift_next[4:0]))
    else $error("register select not latched");

  write_dir_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_sync_reg)
    cmd_done && shift_next[CMD_DIR_BIT] |=> state_reg == ST_WR && !dout_oe_out)
    else $error("write command not honoured");

  read_dir_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_sync_reg)
    cmd_done && !shift_next[CMD_DIR_BIT] |=> state_reg == ST_RD && dout_oe_out)
    else $error("read command not honoured");

  mode_load_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_sync_reg)
    wr_done && addr_reg == MODE_ADDR && !shift_next[6] |=> mode_reg == $past(shift_next))
    else $error("configuration write lost");

  temp_clear_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_sync_reg)
    temp_done_in && !wr_done && state_reg != ST_RST |=> !mode_reg.temp_conversion_start)
    else $error("temperature start not cleared");

  soft_quiet_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_sync_reg)
    wr_done && addr_reg == MODE_ADDR && shift_next[6] |=> rst_quiet_s ##0 soft_reset_out)
    else $error("soft reset quiet time too short");

  read_len_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_sync_reg)
    rd_done |=> state_reg == ST_CMD && !dout_oe_out)
    else $error("read ran past register width");

  wave_rate_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_sync_reg)
    wave_reg && $stable(mode_reg.waveform_rate_sel) |=> !wave_reg [*8])
    else $error("waveform strobe too frequent");

endmodule // mra_top

// File: verif/mra_host_model.sv
// host-side serial master model for the meter register front end
`timescale 1ns/1ps
module mra_host_model
  import mra_pkg::*;
(
  input wire logic clk_in, // system clock
  input wire logic dout_in, // device read data
  input wire logic oe_in, // device drives dout
  output mra_serial_in_s ser_out // serial pins
);
  // idle: clock parked high, frame closed
  initial
  begin
    ser_out = 3'b101;
  end
  // ==========================================================
  // one bit: data set while clock low, read data taken before the rise
  task automatic bit_x(input logic b, output logic q);
    @(negedge clk_in);
    ser_out.sclk = 1'b0;
    ser_out.din = b;
    repeat (3) @(negedge clk_in);
    q = dout_in & oe_in;
    ser_out.sclk = 1'b1;
    @(negedge clk_in);
  endtask
  // ==========================================================
  // one frame: command byte then n data bits, msb first
  task automatic frame(input logic [7:0] cmd, input logic [15:0] wd, input int n,
                       output logic [15:0] rd);
    logic q;
    rd = 16'h0000;
    @(negedge clk_in);
    ser_out.cs_n = 1'b0;
    // command always first, bits 6:5 sent as zero
    for (int i = 7; i >= 0; i--) bit_x(cmd[i] & (i < 5 || i > 6), q);
    for (int i = n - 1; i >= 0; i--)
    begin
      bit_x(wd[i], q);
      rd[i] = q;
    end
    repeat (2) @(negedge clk_in);
    ser_out.cs_n = 1'b1;
    // released line must not show the last bit
    ser_out.din = ~ser_out.din;
  endtask
endmodule // mra_host_model

// File: verif/mra_top_tb_top.sv
// self-checking bench for the meter register front end
`timescale 1ns/1ps
module mra_top_tb_top;
  import mra_pkg::*;
  logic sys_clk_in; // master clock
  logic rstn_in; // reset, low active
  logic temp_done_in; // conversion finished
  mra_serial_in_s serial_in; // host pins
  logic dout_out; // read data
  logic dout_oe_out; // read data enable
  mra_mode_s mode_out; // configuration
  logic soft_reset_out; // quiet time flag
  logic wave_update_out; // waveform strobe
  int failures; // mismatches
  int n_compared; // comparisons
  logic [15:0] rd; // last read data
  mra_top mra_top_inst (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .serial_in(serial_in),
    .temp_done_in(temp_done_in), .dout_out(dout_out), .dout_oe_out(dout_oe_out),
    .mode_out(mode_out), .soft_reset_out(soft_reset_out), .wave_update_out(wave_update_out));
  mra_host_model mra_host_model_inst (.clk_in(sys_clk_in), .dout_in(dout_out),
    .oe_in(dout_oe_out), .ser_out(serial_in));
  // 10 MHz clock
  initial
  begin
    sys_clk_in = 1'b0;
    forever #50 sys_clk_in = ~sys_clk_in;
  end
  // ==========================================================
  // helpers
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d, input int n);
    mra_host_model_inst.frame({3'b100, a}, d, n, rd);
  endtask
  task automatic rdr(input logic [4:0] a, input int n);
    mra_host_model_inst.frame({3'b000, a}, 16'h0000, n, rd);
  endtask
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset;
    chk("mode at reset", MODE_RESET, mode_out);
    chk("oe idle", 16'h0000, 16'(dout_oe_out));
    rdr(MODE_ADDR, 16);
    chk("mode read", MODE_RESET, rd);
    chk("oe released", 16'h0000, 16'(dout_oe_out));
  endtask
  // single control bits; suspend only briefly, test bit kept 0
  task automatic t_fields;
    int pos[9] = '{0, 1, 2, 3, 4, 7, 8, 9, 10};
    for (int i = 0; i < 9; i++)
    begin
      wr(MODE_ADDR, 16'h0001 << pos[i], 16);
      chk("mode bit", 16'h0001 << pos[i], mode_out);
      rdr(MODE_ADDR, 16);
      chk("mode bit read", 16'h0001 << pos[i], rd);
    end
  endtask
  // every rate and source code
  task automatic t_wave;
    int c;
    for (int r = 0; r < 4; r++)
    begin
      wr(MODE_ADDR, (16'(r) << RATE_LSB) | (16'(3 - r) << SRC_LSB), 16);
      chk("source", 16'(3 - r), 16'(mode_out.waveform_source_sel));
      c = 0;
      while (wave_update_out !== 1'b1 && c < 2100)
      begin
        @(negedge sys_clk_in);
        c++;
      end
      c = 0;
      do
      begin
        @(negedge sys_clk_in);
        c++;
      end while (wave_update_out !== 1'b1 && c < 2100);
      chk("wave period", 16'(128 << r), 16'(c));
    end
  endtask
  task automatic t_temp;
    wr(MODE_ADDR, 16'h0020, 16);
    chk("temp start", 16'h0001, 16'(mode_out.temp_conversion_start));
    repeat (3) @(negedge sys_clk_in);
    temp_done_in = 1'b1;
    @(negedge sys_clk_in);
    temp_done_in = 1'b0;
    @(negedge sys_clk_in);
    chk("temp cleared", 16'h0000, mode_out);
  endtask
  // address differs from the mode only in bit 4, then resync
  task automatic t_other;
    wr(MODE_ADDR, 16'h0381, 16);
    wr(5'h16, 16'h00A5, 8);
    rdr(MODE_ADDR, 16);
    chk("mode kept", 16'h0381, rd);
    rdr(5'h16, 8);
    chk("other read", 16'h0000, rd);
    wr(MODE_ADDR, 16'h0003, 5);
    chk("aborted write", 16'h0381, mode_out);
  endtask
  task automatic t_soft_chip_reset;
    wr(MODE_ADDR, 16'h0040, 16);
    chk("reset active", 16'h0001, 16'(soft_reset_out));
    chk("mode default", MODE_RESET, mode_out);
    repeat (SOFT_CHIP_RESET_CYC) @(negedge sys_clk_in); // host stays quiet
    chk("reset over", 16'h0000, 16'(soft_reset_out));
    rdr(MODE_ADDR, 16);
    chk("mode after reset", MODE_RESET, rd);
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    failures = 0;
    n_compared = 0;
    rstn_in = 1'b0;
    temp_done_in = 1'b0;
    repeat (5) @(negedge sys_clk_in);
    rstn_in = 1'b1;
    repeat (4) @(negedge sys_clk_in);
    t_reset();
    t_fields();
    t_wave();
    t_temp();
    t_other();
    t_soft_chip_reset();
    final_report();
  end
  // watchdog
  initial
  begin
    repeat (60000) @(posedge sys_clk_in);
    failures++;
    final_report();
  end
endmodule // mra_top_tb_top
